//--- tmwg_load_model.sv
// tmwg_load_model: load on both waveform pins, each line with a pull-down
// assumes pins and enables come from the timer block on clk_i
`timescale 1ns/1ns
module tmwg_load (
  // clock and measurement control
  input  wire logic        clk_i,
  input  wire logic        start_i,
  input  wire logic        meas_i,
  // pins from the block
  input  wire logic        pin_a_i,
  input  wire logic        pin_b_i,
  input  wire logic [1:0]  drive_en_i,
  // measured figures
  output logic      [15:0] hi_a_o,
  output logic      [15:0] hi_b_o,
  output logic      [15:0] rise_a_o
);
  logic line_q;
  // an undriven line falls to its pull-down
  wire  line_a = drive_en_i[0] ? pin_a_i : 1'b0;
  wire  line_b = drive_en_i[1] ? pin_b_i : 1'b0;

  // count high cycles and rising edges while measuring
  always_ff @(posedge clk_i) begin
    line_q <= line_a;
    if (start_i) begin
      hi_a_o   <= 16'h0000;
      hi_b_o   <= 16'h0000;
      rise_a_o <= 16'h0000;
    end else if (meas_i) begin
      hi_a_o   <= hi_a_o + {15'h0000, line_a};
      hi_b_o   <= hi_b_o + {15'h0000, line_b};
      rise_a_o <= rise_a_o + {15'h0000, line_a & ~line_q};
    end
  end
endmodule

//--- tmwg_pkg.sv
// tmwg_pkg: constants, register map and carrier types of the 16-bit timer waveform block
// assumes a classic wishbone slave with 32-bit data and byte addresses
package tmwg_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL_A   = 8'h00; // waveform control a
  localparam logic [7:0] ADDR_CTRL_B   = 8'h04; // timer control b (mode high bits)
  localparam logic [7:0] ADDR_CMP_A    = 8'h08; // channel a compare value
  localparam logic [7:0] ADDR_CMP_B    = 8'h0C; // channel b compare value
  localparam logic [7:0] ADDR_CAPTURE  = 8'h10; // capture value register
  localparam logic [7:0] ADDR_COUNT    = 8'h14; // counter value (read only)
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18; // sticky event flags, write one to clear
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C; // event mask
  localparam logic [7:0] ADDR_STATE    = 8'h20; // waveforms, override, direction (read only)
  // control a field positions
  localparam int CA_ACT_A_LSB = 6;
  localparam int CA_ACT_B_LSB = 4;
  localparam int CA_MODE_LSB  = 0;
  localparam logic [7:0] CA_WR_MASK = 8'hF3; // bits 3:2 unimplemented
  // control b field positions
  localparam int CB_MODE_LSB = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // event flag positions
  localparam int EV_WRAP  = 0;
  localparam int EV_MATCH_A = 1;
  localparam int EV_MATCH_B = 2;
  localparam int EV_W = 3;
  // fixed top values and limits
  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  // compare output field encodings
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  // waveform families, one-hot
  typedef enum logic [3:0] {
    TMWG_NORMAL = 4'b0001,
    TMWG_CTC    = 4'b0010,
    TMWG_FAST   = 4'b0100,
    TMWG_DUAL   = 4'b1000
  } tmwg_family_t;

  // decoded mode properties
  typedef struct packed {
    tmwg_family_t family;
    logic [15:0]  top_fixed;
    logic         top_from_cap;
    logic         top_from_cmpa;
    logic         load_at_bottom;
    logic         buffered;
    logic         wrap_at_top;
    logic         wrap_at_bottom;
    logic         toggle_ok;
  } tmwg_mode_t;

  // wishbone request carrier
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tmwg_wb_req_t;

  // mode decode table
  function automatic tmwg_mode_t tmwg_decode(input logic [3:0] m);
    tmwg_mode_t d;
    d = '{family: TMWG_NORMAL, top_fixed: CNT_MAX, top_from_cap: 1'b0,
          top_from_cmpa: 1'b0, load_at_bottom: 1'b0, buffered: 1'b0,
          wrap_at_top: 1'b0, wrap_at_bottom: 1'b0, toggle_ok: 1'b0};
    case (m)
      4'h0: d.family = TMWG_NORMAL;
      4'h1, 4'h2, 4'h3: begin
        d.family = TMWG_DUAL;
        d.top_fixed = (m == 4'h1) ? TOP_8BIT : (m == 4'h2) ? TOP_9BIT : TOP_10BIT;
        d.buffered = 1'b1;
        d.wrap_at_bottom = 1'b1;
      end
      4'h4: begin
        d.family = TMWG_CTC;
        d.top_from_cmpa = 1'b1;
      end
      4'h5, 4'h6, 4'h7: begin
        d.family = TMWG_FAST;
        d.top_fixed = (m == 4'h5) ? TOP_8BIT : (m == 4'h6) ? TOP_9BIT : TOP_10BIT;
        d.buffered = 1'b1;
        d.wrap_at_top = 1'b1;
      end
      4'h8, 4'h9, 4'hA, 4'hB: begin
        d.family = TMWG_DUAL;
        d.top_from_cap = ~m[0];
        d.top_from_cmpa = m[0];
        d.load_at_bottom = ~m[1];
        d.buffered = 1'b1;
        d.wrap_at_bottom = 1'b1;
        d.toggle_ok = 1'b1;
      end
      4'hC: begin
        d.family = TMWG_CTC;
        d.top_from_cap = 1'b1;
      end
      4'hE, 4'hF: begin
        d.family = TMWG_FAST;
        d.top_from_cap = ~m[0];
        d.top_from_cmpa = m[0];
        d.buffered = 1'b1;
        d.wrap_at_top = 1'b1;
        d.toggle_ok = 1'b1;
      end
      default: d.family = TMWG_NORMAL; // mode 13 reserved: plain count, no wrap flag
    endcase
    return d;
  endfunction
endpackage

//--- tmwg_tb.sv
// tmwg_tb: self-checking bench for the timer waveform block
// assumes one 125 MHz clock and the load model on both pins
`timescale 1ns/1ns
module tb_top;
  import tmwg_pkg::*;
  logic         clk_i   = 1'b0;
  logic         rst_b_i = 1'b0;
  tmwg_wb_req_t req     = '0;
  logic         tick    = 1'b0;
  logic [1:0]   pdir    = 2'h0;
  logic [1:0]   pval    = 2'h0;
  logic         meas    = 1'b0;
  logic         start   = 1'b0;
  logic [31:0]  q;
  wire  [31:0]  rdat;
  wire          ack;
  wire          pin_a;
  wire          pin_b;
  wire          irq;
  wire  [1:0]   den;
  wire  [15:0]  hi_a;
  wire  [15:0]  hi_b;
  wire  [15:0]  rise_a;
  int           mismatches = 0;
  int           tests_run  = 0;

  // 8 ns clock
  always #4 clk_i = ~clk_i;

  tmwg_timer i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .wb_req_i(req), .wb_dat_o(rdat),
    .wb_ack_o(ack), .timer_count_enable_i(tick), .port_dir_i(pdir), .port_val_i(pval),
    .chan_a_wave_pin_o(pin_a), .chan_b_wave_pin_o(pin_b), .pin_drive_en_o(den), .irq_o(irq));
  tmwg_load i_load (.clk_i(clk_i), .start_i(start), .meas_i(meas), .pin_a_i(pin_a),
    .pin_b_i(pin_b), .drive_en_i(den), .hi_a_o(hi_a), .hi_b_o(hi_b), .rise_a_o(rise_a));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one classic cycle: hold until ack, take data, release for a cycle
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: wr, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    q = rdat;
    req <= '0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic restart();
    rst_b_i <= 1'b0;
    tick    <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask

  // clear the load's figures, then sample n cycles
  task automatic measure(input int n);
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    meas  <= 1'b1;
    repeat (n) @(posedge clk_i);
    meas  <= 1'b0;
    @(posedge clk_i);
  endtask

  // reset values, unused bits, unmapped place
  task automatic t_regs();
    restart();
    rd_chk(ADDR_CTRL_A, 32'h0);
    rd_chk(ADDR_CTRL_B, 32'h0);
    rd_chk(ADDR_IRQ_STAT, 32'h0);
    xfer(1'b1, ADDR_CTRL_A, 32'hFF);
    rd_chk(ADDR_CTRL_A, 32'hF3);
    xfer(1'b1, 8'h40, 32'hFF);
    rd_chk(8'h40, 32'h0);
    $display("test regs done");
  endtask

  // zero fields leave pins to the port; no direction, no drive
  task automatic t_port();
    restart();
    pdir <= 2'h3;
    pval <= 2'h2;
    measure(20);
    chk({16'h0, hi_a}, 32'h0);
    chk({16'h0, hi_b}, 32'd20);
    pdir <= 2'h1;
    measure(20);
    chk({16'h0, hi_b}, 32'h0);
    $display("test port done");
  endtask

  // clear-on-match mode 4, toggle on match, events and interrupt
  task automatic t_ctc();
    restart();
    pdir <= 2'h3;
    xfer(1'b1, ADDR_CMP_A, 32'h3);
    xfer(1'b1, ADDR_CTRL_B, 32'h08);
    xfer(1'b1, ADDR_CTRL_A, 32'h40);
    fork
      measure(50);
      begin
        tick <= 1'b1;
        repeat (40) @(posedge clk_i);
        tick <= 1'b0;
      end
    join
    chk({16'h0, rise_a}, 32'd5);
    chk({31'h0, irq}, 32'h0);
    rd_chk(ADDR_IRQ_STAT, 32'h6);
    xfer(1'b1, ADDR_IRQ_MASK, 32'h2);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, ADDR_IRQ_STAT, 32'h6);
    chk({31'h0, irq}, 32'h0);
    rd_chk(ADDR_IRQ_STAT, 32'h0);
    $display("test ctc done");
  endtask

  // fast pwm mode 5: a clears on match, b compare at top
  task automatic t_fast();
    restart();
    pdir <= 2'h3;
    xfer(1'b1, ADDR_CMP_A, 32'h3F);
    xfer(1'b1, ADDR_CMP_B, 32'hFF);
    xfer(1'b1, ADDR_CTRL_B, 32'h08);
    xfer(1'b1, ADDR_CTRL_A, 32'hB1);
    xfer(1'b1, ADDR_IRQ_MASK, 32'h1);
    tick <= 1'b1;
    repeat (300) @(posedge clk_i);
    measure(512);
    tick <= 1'b0;
    chk({16'h0, hi_a}, 32'd128);
    chk({16'h0, hi_b}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(q & 32'h1, 32'h1);
    $display("test fast done");
  endtask

  // dual slope mode 1: a clears up and sets down, b field 01 leaves the pin to the port
  task automatic t_dual();
    restart();
    pdir <= 2'h3;
    pval <= 2'h2;
    xfer(1'b1, ADDR_CMP_A, 32'h40);
    xfer(1'b1, ADDR_CTRL_A, 32'h91);
    tick <= 1'b1;
    repeat (600) @(posedge clk_i);
    measure(510);
    tick <= 1'b0;
    chk({16'h0, hi_a}, 32'd128);
    chk({16'h0, hi_b}, 32'd510);
    xfer(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(q & 32'h1, 32'h1);
    $display("test dual done");
  endtask

  // mode 9: top from compare a, channel a toggles at top for half duty
  task automatic t_pfc();
    restart();
    pdir <= 2'h3;
    xfer(1'b1, ADDR_CMP_A, 32'h0F);
    xfer(1'b1, ADDR_CTRL_B, 32'h10);
    xfer(1'b1, ADDR_CTRL_A, 32'h41);
    tick <= 1'b1;
    repeat (100) @(posedge clk_i);
    measure(60);
    tick <= 1'b0;
    chk({16'h0, hi_a}, 32'd30);
    chk({16'h0, rise_a}, 32'h1);
    xfer(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(q & 32'h1, 32'h1);
    $display("test pfc done");
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_regs();
    t_port();
    t_ctc();
    t_fast();
    t_dual();
    t_pfc();
    finish_test();
  end
endmodule

//--- tmwg_timer.sv
// tmwg_timer: 16-bit timer counter with mode decode, compare buffers and waveform outputs
// assumes a classic wishbone master on clk_i and a one-cycle count enable from a prescaler
//
// Operation
// - all logic on clk_i; the prescaled tick only enables counting for one cycle
// - phase and frequency correct modes load compare buffers at bottom
// - nonzero output field hands the pin to the waveform, except a pwm field 01 without toggle action; zero leaves the port
// - non-pwm: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast pwm: 10 clear on match set at top; 11 the reverse
// - fast pwm field 01 toggles channel a only in modes 14, 15
// - fast pwm: compare equal to top with upper bit set takes top action only
// - dual slope: 10 clears on up match, sets on down; 11 reverse
// - dual slope field 01 toggles channel a only in modes 8 to 11
// - four-bit mode split over control a and b selects sequence, top, waveform
// - modes 1-3 dual slope, fixed top, load at top, wrap flag at bottom
// - modes 5-7 fast pwm, fixed top, load at top, wrap flag at top
// - mode 0 counts to max; modes 4, 12 clear on match; immediate; flag at max
// - top source per mode; 10-11 and 14-15 load and flag as listed; 13 reserved
// - compare values double buffered only in pwm modes
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module tmwg_timer
  import tmwg_pkg::*;
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  // wishbone slave
  input  wire tmwg_pkg::tmwg_wb_req_t wb_req_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  // timer count enable and port control
  input  wire logic                timer_count_enable_i,
  input  wire logic [1:0]          port_dir_i,
  input  wire logic [1:0]          port_val_i,
  // pins and interrupt
  output logic                     chan_a_wave_pin_o,
  output logic                     chan_b_wave_pin_o,
  output logic [1:0]               pin_drive_en_o,
  output logic                     irq_o
);
  import tmwg_pkg::*;

  // registers
  logic [7:0]  timer_waveform_control_a;
  logic [7:0]  timer_control_b;
  logic [15:0] chan_a_compare_value;
  logic [15:0] chan_b_compare_value;
  logic [15:0] cmp_buf_a;
  logic [15:0] cmp_buf_b;
  logic [15:0] capture_value_reg;
  logic [15:0] counter_value;
  logic        count_down;
  logic [1:0]  wave;
  logic [EV_W-1:0] irq_stat;
  logic [EV_W-1:0] irq_mask;

  // bus decode
  wire         bus_req   = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  wire         bus_wr    = bus_req & wb_req_i.we;
  wire         lane0     = wb_req_i.sel[0];
  wire         lane1     = wb_req_i.sel[1];
  wire [7:0]   adr       = wb_req_i.adr;
  wire [31:0]  wdat      = wb_req_i.dat;
  wire         wr_ca     = bus_wr & lane0 & (adr == ADDR_CTRL_A);
  wire         wr_cb     = bus_wr & lane0 & (adr == ADDR_CTRL_B);
  wire         wr_cmpa   = bus_wr & (adr == ADDR_CMP_A);
  wire         wr_cmpb   = bus_wr & (adr == ADDR_CMP_B);
  wire         wr_cap    = bus_wr & (adr == ADDR_CAPTURE);
  wire         wr_stat   = bus_wr & lane0 & (adr == ADDR_IRQ_STAT);
  wire         wr_mask   = bus_wr & lane0 & (adr == ADDR_IRQ_MASK);

  // mode assembly and decode
  wire [3:0]   waveform_mode_select = {timer_control_b[CB_MODE_LSB+1 -: 2],
                                       timer_waveform_control_a[CA_MODE_LSB +: 2]};
  tmwg_mode_t  md;
  assign md = tmwg_decode(waveform_mode_select);
  wire         is_fast  = (md.family == TMWG_FAST);
  wire         is_dual  = (md.family == TMWG_DUAL);
  wire         is_pwm   = is_fast | is_dual;
  wire [1:0]   chan_a_output_action = timer_waveform_control_a[CA_ACT_A_LSB +: 2];
  wire [1:0]   chan_b_output_action = timer_waveform_control_a[CA_ACT_B_LSB +: 2];

  // top selection
  wire [15:0]  top_val = md.top_from_cap  ? capture_value_reg :
                         md.top_from_cmpa ? chan_a_compare_value :
                         md.top_fixed;
  wire         tick    = timer_count_enable_i;
  wire         at_top  = (counter_value == top_val);
  wire         at_bot  = (counter_value == CNT_BOTTOM);
  wire         at_max  = (counter_value == CNT_MAX);

  // next counter value and direction
  logic [15:0] next_count;
  logic        next_down;
  always_comb begin
    next_count = counter_value;
    next_down  = count_down;
    if (tick) begin
      if (is_dual) begin
        if (!count_down && at_top) begin
          next_down  = 1'b1;
          next_count = counter_value - 16'h0001;
        end else if (count_down && at_bot) begin
          next_down  = 1'b0;
          next_count = counter_value + 16'h0001;
        end else if (count_down) begin
          next_count = counter_value - 16'h0001;
        end else begin
          next_count = counter_value + 16'h0001;
        end
      end else if ((is_fast || md.family == TMWG_CTC) && at_top) begin
        next_down  = 1'b0;
        next_count = CNT_BOTTOM;
      end else begin
        next_down  = 1'b0;
        next_count = counter_value + 16'h0001; // wraps at max
      end
    end
  end

  // buffer load point: top, or bottom for phase and frequency correct
  wire load_pt   = md.load_at_bottom ? (at_bot & count_down) : at_top;
  wire do_load   = tick & md.buffered & load_pt;
  wire wrap_ev   = tick & ((md.wrap_at_top & at_top) |
                           (md.wrap_at_bottom & at_bot & count_down) |
                           (~is_pwm & at_max &
                            (waveform_mode_select != 4'hD)));

  // compare match
  wire match_a   = tick & (counter_value == chan_a_compare_value);
  wire match_b   = tick & (counter_value == chan_b_compare_value);
  wire top_tick  = tick & at_top;

  // waveform next value per channel
  function automatic logic wave_next(input logic cur, input logic [1:0] act,
                                     input logic match, input logic cmp_is_top,
                                     input logic chan_a);
    logic n;
    n = cur;
    if (is_fast) begin
      if (act[1]) begin
        if (top_tick)
          n = act[0] ? 1'b0 : 1'b1;
        else if (match && !cmp_is_top)
          n = act[0];
      end else if (act == ACT_TOGGLE && chan_a && md.toggle_ok && match) begin
        n = ~cur;
      end
    end else if (is_dual) begin
      if (act[1] && match)
        n = count_down ? ~act[0] : act[0];
      else if (act == ACT_TOGGLE && chan_a && md.toggle_ok && match)
        n = ~cur;
    end else if (match) begin
      case (act)
        ACT_TOGGLE: n = ~cur;
        ACT_CLEAR:  n = 1'b0;
        ACT_SET:    n = 1'b1;
        default:    n = cur;
      endcase
    end
    return n;
  endfunction

  // next waveform per channel; a process, so signals read inside the function are watched
  logic [1:0] next_wave;
  always_comb begin
    next_wave[0] = wave_next(wave[0], chan_a_output_action, match_a,
                             chan_a_compare_value == top_val, 1'b1);
    next_wave[1] = wave_next(wave[1], chan_b_output_action, match_b,
                             chan_b_compare_value == top_val, 1'b0);
  end

  // pin override: a set field bit takes the pin, but a pwm toggle field left
  // without a toggle action is disconnected and the port keeps the pin
  wire       dis_a    = is_pwm & (chan_a_output_action == ACT_TOGGLE) & ~md.toggle_ok;
  wire       dis_b    = is_pwm & (chan_b_output_action == ACT_TOGGLE);
  wire [1:0] override = {(|chan_b_output_action) & ~dis_b,
                         (|chan_a_output_action) & ~dis_a};
  wire [1:0] next_pin = {override[1] ? wave[1] : port_val_i[1],
                         override[0] ? wave[0] : port_val_i[0]};

  // event flags: hardware set wins over write-one-clear
  wire [EV_W-1:0] ev_set  = {match_b, match_a, wrap_ev};
  wire [EV_W-1:0] ev_clr  = wr_stat ? wdat[EV_W-1:0] : '0;
  wire [EV_W-1:0] next_stat = (irq_stat & ~ev_clr) | ev_set;

  // read mux
  logic [31:0] rdata;
  always_comb begin
    if (adr == ADDR_CTRL_A)
      rdata = {24'h0, timer_waveform_control_a};
    else if (adr == ADDR_CTRL_B)
      rdata = {24'h0, timer_control_b};
    else if (adr == ADDR_CMP_A)
      rdata = {16'h0, cmp_buf_a};
    else if (adr == ADDR_CMP_B)
      rdata = {16'h0, cmp_buf_b};
    else if (adr == ADDR_CAPTURE)
      rdata = {16'h0, capture_value_reg};
    else if (adr == ADDR_COUNT)
      rdata = {16'h0, counter_value};
    else if (adr == ADDR_IRQ_STAT)
      rdata = {29'h0, irq_stat};
    else if (adr == ADDR_IRQ_MASK)
      rdata = {29'h0, irq_mask};
    else if (adr == ADDR_STATE)
      rdata = {24'h0, 2'h0, port_dir_i, override, wave};
    else
      rdata = 32'h0; // unmapped reads zero, writes ignored
  end

  // 16-bit write data respects byte lanes
  function automatic logic [15:0] lane_merge(input logic [15:0] old);
    return {lane1 ? wdat[15:8] : old[15:8], lane0 ? wdat[7:0] : old[7:0]};
  endfunction

  // bus answer: ack one cycle after the request
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rdata : 32'h0;
    end
  end

  // control, mask and capture registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_waveform_control_a <= CTRL_RESET;
      timer_control_b          <= CTRL_RESET;
      irq_mask                 <= '0;
      capture_value_reg        <= 16'h0;
    end else begin
      if (wr_ca)
        timer_waveform_control_a <= wdat[7:0] & CA_WR_MASK;
      if (wr_cb)
        timer_control_b <= wdat[7:0];
      if (wr_mask)
        irq_mask <= wdat[EV_W-1:0];
      if (wr_cap)
        capture_value_reg <= lane_merge(capture_value_reg);
    end
  end

  // compare buffers and active compare values
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmp_buf_a            <= 16'h0;
      cmp_buf_b            <= 16'h0;
      chan_a_compare_value <= 16'h0;
      chan_b_compare_value <= 16'h0;
    end else begin
      if (wr_cmpa)
        cmp_buf_a <= lane_merge(cmp_buf_a);
      if (wr_cmpb)
        cmp_buf_b <= lane_merge(cmp_buf_b);
      if (!md.buffered) begin
        chan_a_compare_value <= wr_cmpa ? lane_merge(cmp_buf_a) : cmp_buf_a;
        chan_b_compare_value <= wr_cmpb ? lane_merge(cmp_buf_b) : cmp_buf_b;
      end else if (do_load) begin
        chan_a_compare_value <= cmp_buf_a;
        chan_b_compare_value <= cmp_buf_b;
      end
    end
  end

  // counter, waveform and flags
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      counter_value <= 16'h0;
      count_down    <= 1'b0;
      wave          <= 2'b00;
      irq_stat      <= '0;
    end else begin
      counter_value <= next_count;
      count_down    <= next_down;
      wave          <= next_wave;
      irq_stat      <= next_stat;
    end
  end

  // pins and interrupt from flops; drive enable follows port direction only
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chan_a_wave_pin_o <= 1'b0;
      chan_b_wave_pin_o <= 1'b0;
      pin_drive_en_o    <= 2'b00;
      irq_o             <= 1'b0;
    end else begin
      chan_a_wave_pin_o <= next_pin[0];
      chan_b_wave_pin_o <= next_pin[1];
      pin_drive_en_o    <= port_dir_i;
      irq_o             <= |(next_stat & irq_mask);
    end
  end
endmodule

//--- tmwg_timer_properties.sv
// tmwg_timer_properties: port-level checks on the timer waveform block
// assumes a classic wishbone master that holds each request until ack
`timescale 1ns/1ns
module tmwg_props
  import tmwg_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  // register bus
  input  wire tmwg_pkg::tmwg_wb_req_t wb_req_i,
  input  wire logic [31:0]            wb_dat_o,
  input  wire logic                   wb_ack_o,
  // timer and pins
  input  wire logic                   timer_count_enable_i,
  input  wire logic [1:0]             port_dir_i,
  input  wire logic [1:0]             port_val_i,
  input  wire logic                   chan_a_wave_pin_o,
  input  wire logic                   chan_b_wave_pin_o,
  input  wire logic [1:0]             pin_drive_en_o,
  input  wire logic                   irq_o
);
  logic [7:0] ctrl_q;
  logic [2:0] mask_q;
  logic [1:0] up_cnt;
  // request decode and helper views
  wire        req_on = wb_req_i.cyc & wb_req_i.stb;
  wire        taken  = req_on & ~wb_ack_o;
  wire        wr_sel = taken & wb_req_i.we & wb_req_i.sel[0];
  wire        rd_ack = wb_ack_o & ~wb_req_i.we;
  wire        live   = (up_cnt == 2'h3); // pins settled after reset
  wire [1:0]  act_a  = ctrl_q[7:6];
  wire [1:0]  act_b  = ctrl_q[5:4];
  wire        pv_a   = port_val_i[0];
  wire        pv_b   = port_val_i[1];

  // shadow of control a and mask as software wrote them
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q <= 8'h00;
      mask_q <= 3'h0;
      up_cnt <= 2'h0;
    end else begin
      up_cnt <= live ? up_cnt : up_cnt + 2'h1;
      if (wr_sel && wb_req_i.adr == ADDR_CTRL_A) ctrl_q <= wb_req_i.dat[7:0] & CA_WR_MASK;
      if (wr_sel && wb_req_i.adr == ADDR_IRQ_MASK) mask_q <= wb_req_i.dat[2:0];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // a taken request is answered by a one-cycle ack
  sequence s_taken;
    taken;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  ack_answer_a: assert property (s_taken |=> s_ack_pulse)
    else $error("ack missing or longer than one cycle");
  ack_source_a: assert property (wb_ack_o |-> $past(req_on))
    else $error("ack without a request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  ctrl_read_a: assert property (
    rd_ack && wb_req_i.adr == ADDR_CTRL_A |-> wb_dat_o[7:0] == ctrl_q && wb_dat_o[3:2] == 2'h0)
    else $error("control a read back wrong");
  unmapped_zero_a: assert property (rd_ack && wb_req_i.adr >= 8'h24 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  port_pass_a: assert property (
    live && act_a == 2'h0 && $past(act_a) == 2'h0 |-> chan_a_wave_pin_o == $past(pv_a))
    else $error("channel a pin not under port control");
  port_pass_b_a: assert property (
    live && act_b == 2'h0 && $past(act_b) == 2'h0 |-> chan_b_wave_pin_o == $past(pv_b))
    else $error("channel b pin not under port control");
  irq_mask_a: assert property (irq_o |-> (mask_q | $past(mask_q)) != 3'h0)
    else $error("interrupt high with all events masked");
  irq_tick_a: assert property (
    $rose(irq_o) && mask_q == $past(mask_q, 2) |-> $past(timer_count_enable_i))
    else $error("event flagged without a count tick");
endmodule

bind tmwg_timer tmwg_props i_props (
  .clk_i                (clk_i),
  .rst_b_i              (rst_b_i),
  .wb_req_i             (wb_req_i),
  .wb_dat_o             (wb_dat_o),
  .wb_ack_o             (wb_ack_o),
  .timer_count_enable_i (timer_count_enable_i),
  .port_dir_i           (port_dir_i),
  .port_val_i           (port_val_i),
  .chan_a_wave_pin_o    (chan_a_wave_pin_o),
  .chan_b_wave_pin_o    (chan_b_wave_pin_o),
  .pin_drive_en_o       (pin_drive_en_o),
  .irq_o                (irq_o)
);
